// [hdl/tpw_pkg.sv]
// Constants shared by the tick prescaler and timeout guard.
// Assumes an 8-bit special-function register port with addresses 00..FF.
package tpw_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_MS_DIV_LOW  = 8'hFC;
    localparam logic [7:0] ADDR_MS_DIV_HIGH = 8'hFD;
    localparam logic [7:0] ADDR_HMS_DIV     = 8'hFE;
    localparam logic [7:0] ADDR_GUARD_CTRL  = 8'hFF;
    // Values after reset
    localparam logic [7:0] RST_MS_DIV_LOW   = 8'h9F;
    localparam logic [7:0] RST_MS_DIV_HIGH  = 8'h0F;
    localparam logic [7:0] RST_HMS_DIV      = 8'h63;
    localparam logic [7:0] RST_GUARD_CTRL   = 8'h00;
    // Control field positions
    localparam int unsigned BIT_ENABLE_SEQ  = 7;
    localparam int unsigned BIT_DISABLE_SEQ = 6;
    localparam int unsigned BIT_RESTART_SEQ = 5;
    localparam int unsigned COUNT_MSB       = 4;
    localparam int unsigned COUNT_W         = 5;
endpackage

// [hdl/tpw_divider.sv]
// Reloading divider: one-cycle tick every (divisor + 1) enabled cycles.
// Assumes step_en is a single-cycle pulse or a constant high level.
`timescale 1ns/1ps
module tpw_divider #(
    parameter int unsigned WIDTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Control
    input  wire logic             step_en,
    input  wire logic [WIDTH-1:0] divisor,
    // Result
    output logic                  tick_q
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;
    wire              wrap = (cnt_q >= divisor);   // >= so a lowered divisor never overruns

    assign cnt_d = !step_en ? cnt_q : (wrap ? '0 : cnt_q + 1'b1);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= step_en && wrap;
        end
    end

    div_wrap_tick_a: assert property (@(posedge clk) disable iff (!reset_n)
        (step_en && cnt_q == divisor) |=> (tick_q && cnt_q == '0))
        else $error("divider did not tick on reaching its divisor");
    div_no_early_a: assert property (@(posedge clk) disable iff (!reset_n)
        tick_q |-> $past(step_en))
        else $error("divider ticked without a step");
endmodule // tpw_divider

// [hdl/tpw_guard.sv]
// Top of the tick prescaler with its timeout guard counter.
// Assumes single-cycle register strobes on the system clock; one access at a time.
`timescale 1ns/1ps
module tpw_guard (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Special-function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata_q,
    // Ticks and expiry
    output logic            ms_tick_q,
    output logic            hms_tick_q,
    output logic            guard_running_q,
    output logic            guard_expired_q
);
    logic [7:0]                      ms_div_low_q;
    logic [7:0]                      ms_div_high_q;
    logic [7:0]                      hms_div_q;
    logic [tpw_pkg::COUNT_W-1:0]     guard_timeout_count_q;
    logic [2:0]                      seq_armed_q;   // bits 7..5 as last written
    logic [tpw_pkg::COUNT_W:0]       guard_cnt_q;
    logic [tpw_pkg::COUNT_W:0]       guard_cnt_d;
    logic                            running_d;
    logic                            ms_tick;
    logic                            hms_tick;

    // Expiry point of the guard counter, shared by the logic and its checks
    function automatic logic [tpw_pkg::COUNT_W:0] expiry_limit(
        input logic [tpw_pkg::COUNT_W-1:0] count
    );
        expiry_limit = {1'b0, count} + 1'b1;
    endfunction

    // Register decode
    wire wr_low   = sfr_wr && sfr_addr == tpw_pkg::ADDR_MS_DIV_LOW;
    wire wr_high  = sfr_wr && sfr_addr == tpw_pkg::ADDR_MS_DIV_HIGH;
    wire wr_hms   = sfr_wr && sfr_addr == tpw_pkg::ADDR_HMS_DIV;
    wire wr_ctrl  = sfr_wr && sfr_addr == tpw_pkg::ADDR_GUARD_CTRL;
    wire [2:0] new_seq = sfr_wdata[tpw_pkg::BIT_ENABLE_SEQ:tpw_pkg::BIT_RESTART_SEQ];

    // Falling sequence per bit: armed by a 1, fired by the following 0
    wire [2:0] seq_fire   = wr_ctrl ? (seq_armed_q & ~new_seq) : 3'h0;
    wire       fire_en    = seq_fire[2];
    wire       fire_dis   = seq_fire[1];
    wire       fire_rst   = seq_fire[0];
    wire [tpw_pkg::COUNT_W:0] limit = expiry_limit(guard_timeout_count_q);
    // Expiry on the tick after the counter reaches count plus 1, so count plus 2 ticks; the first tick lands anywhere in its period
    // >= so a count lowered below the counter expires at the next tick, not after a wrap
    wire       expire_now = guard_running_q && hms_tick && !fire_rst
                            && guard_cnt_q >= limit;

    // Enable wins if both sequences complete in one write: a guard is safer on
    assign running_d   = fire_en ? 1'b1 : (fire_dis ? 1'b0 : guard_running_q);
    assign guard_cnt_d = (fire_rst || expire_now) ? '0 :
                         (guard_running_q && hms_tick) ? guard_cnt_q + 1'b1 : guard_cnt_q;

    wire [7:0] ctrl_view = {seq_armed_q, guard_timeout_count_q};
    wire [7:0] rd_mux    = (sfr_addr == tpw_pkg::ADDR_MS_DIV_LOW)  ? ms_div_low_q  :
                           (sfr_addr == tpw_pkg::ADDR_MS_DIV_HIGH) ? ms_div_high_q :
                           (sfr_addr == tpw_pkg::ADDR_HMS_DIV)     ? hms_div_q     :
                           (sfr_addr == tpw_pkg::ADDR_GUARD_CTRL)  ? ctrl_view     : 8'h00;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ms_div_low_q          <= tpw_pkg::RST_MS_DIV_LOW;
            ms_div_high_q         <= tpw_pkg::RST_MS_DIV_HIGH;
            hms_div_q             <= tpw_pkg::RST_HMS_DIV;
            seq_armed_q           <= tpw_pkg::RST_GUARD_CTRL[7:5];
            guard_timeout_count_q <= tpw_pkg::RST_GUARD_CTRL[4:0];
        end else begin
            if (wr_low)  ms_div_low_q  <= sfr_wdata;
            if (wr_high) ms_div_high_q <= sfr_wdata;
            if (wr_hms)  hms_div_q     <= sfr_wdata;
            if (wr_ctrl) begin
                seq_armed_q           <= new_seq;
                guard_timeout_count_q <= sfr_wdata[tpw_pkg::COUNT_MSB:0];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            guard_running_q <= 1'b0;
            guard_cnt_q     <= '0;
            guard_expired_q <= 1'b0;
            sfr_rdata_q     <= 8'h00;
            ms_tick_q       <= 1'b0;
            hms_tick_q      <= 1'b0;
        end else begin
            guard_running_q <= running_d;
            guard_cnt_q     <= guard_cnt_d;
            guard_expired_q <= expire_now;
            if (sfr_rd) sfr_rdata_q <= rd_mux;
            ms_tick_q       <= ms_tick;
            hms_tick_q      <= hms_tick;
        end
    end

    // Millisecond prescaler, free running
    tpw_divider #(.WIDTH(16)) u_ms_div (
        .clk     (clk),
        .reset_n (reset_n),
        .step_en (1'b1),
        .divisor ({ms_div_high_q, ms_div_low_q}),
        .tick_q  (ms_tick)
    );

    // Hundred-millisecond prescaler, stepped by the millisecond tick
    tpw_divider #(.WIDTH(8)) u_hms_div (
        .clk     (clk),
        .reset_n (reset_n),
        .step_en (ms_tick),
        .divisor (hms_div_q),
        .tick_q  (hms_tick)
    );

    // Helper: clocks since last millisecond tick, and whether divisors moved
    logic [16:0] gap_q;
    logic        div_moved_q;
    logic        ms_seen_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gap_q       <= '0;
            div_moved_q <= 1'b0;
            ms_seen_q   <= 1'b0;
        end else begin
            gap_q       <= ms_tick ? 17'h00001 : gap_q + 1'b1;
            div_moved_q <= ms_tick ? (wr_low || wr_high) : (div_moved_q || wr_low || wr_high);
            ms_seen_q   <= ms_seen_q || ms_tick;
        end
    end

    // Helper: millisecond ticks since last hundred-ms tick, and whether its divisor moved
    logic [8:0] ms_in_hms_q;
    logic       hms_moved_q;
    logic       hms_seen_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ms_in_hms_q <= '0;
            hms_moved_q <= 1'b0;
            hms_seen_q  <= 1'b0;
        end else begin
            ms_in_hms_q <= hms_tick ? {8'h00, ms_tick} : ms_in_hms_q + {8'h00, ms_tick};
            hms_moved_q <= hms_tick ? wr_hms : (hms_moved_q || wr_hms);
            hms_seen_q  <= hms_seen_q || hms_tick;
        end
    end

    ms_period_a: assert property (@(posedge clk) disable iff (!reset_n)
        (ms_tick && ms_seen_q && !div_moved_q)
            |-> gap_q == {1'b0, ms_div_high_q, ms_div_low_q} + 17'h00001)
        else $error("millisecond tick period wrong");
    hms_follows_ms_a: assert property (@(posedge clk) disable iff (!reset_n)
        hms_tick |-> $past(ms_tick))
        else $error("hundred-ms tick without millisecond tick");
    enable_seq_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_ctrl && seq_armed_q[2] && !sfr_wdata[7]) |=> guard_running_q)
        else $error("enable sequence did not start guard");
    disable_seq_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_ctrl && seq_armed_q[1] && !sfr_wdata[6] && !fire_en) |=> !guard_running_q)
        else $error("disable sequence did not stop guard");
    restart_seq_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_ctrl && seq_armed_q[0] && !sfr_wdata[5]) |=> (guard_cnt_q == '0 && !guard_expired_q))
        else $error("restart sequence did not clear counter");
    expiry_cause_a: assert property (@(posedge clk) disable iff (!reset_n)
        guard_expired_q |-> $past(guard_running_q && hms_tick
                                  && guard_cnt_q >= expiry_limit(guard_timeout_count_q)))
        else $error("guard expired at the wrong count");
    low_readback_a: assert property (@(posedge clk) disable iff (!reset_n)
        (sfr_rd && sfr_addr == tpw_pkg::ADDR_MS_DIV_LOW && !sfr_wr)
            |=> sfr_rdata_q == ms_div_low_q)
        else $error("low divisor byte read back wrong");
    lone_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_ctrl && !seq_armed_q[2] && !guard_running_q) |=> !guard_running_q)
        else $error("guard started without a one-then-zero sequence");

    hms_period_a: assert property (@(posedge clk) disable iff (!reset_n)
        (hms_tick && hms_seen_q && !hms_moved_q)
            |-> ms_in_hms_q == {1'b0, hms_div_q} + 9'h001)
        else $error("hundred-ms tick period wrong");
    hms_lag_a: assert property (@(posedge clk) disable iff (!reset_n)
        hms_tick_q |-> $past(ms_tick_q))
        else $error("hundred-ms tick output not one cycle after millisecond tick");
    expiry_fires_a: assert property (@(posedge clk) disable iff (!reset_n)
        (guard_running_q && hms_tick && !fire_rst && guard_cnt_q >= limit)
            |=> (guard_expired_q && guard_cnt_q == '0 && guard_running_q))
        else $error("guard did not expire at its limit");
    stopped_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
        !guard_running_q |=> !guard_expired_q)
        else $error("stopped guard expired");
    stopped_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!guard_running_q && !fire_rst) |=> $stable(guard_cnt_q))
        else $error("stopped guard counter moved");
    lone_restart_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_ctrl && !seq_armed_q[0] && !hms_tick) |=> $stable(guard_cnt_q))
        else $error("guard counter cleared without a one-then-zero sequence");
    lone_disable_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_ctrl && !seq_armed_q[1] && guard_running_q) |=> guard_running_q)
        else $error("guard stopped without a one-then-zero sequence");
    high_readback_a: assert property (@(posedge clk) disable iff (!reset_n)
        (sfr_rd && sfr_addr == tpw_pkg::ADDR_MS_DIV_HIGH && !sfr_wr)
            |=> sfr_rdata_q == ms_div_high_q)
        else $error("high divisor byte read back wrong");
    hms_readback_a: assert property (@(posedge clk) disable iff (!reset_n)
        (sfr_rd && sfr_addr == tpw_pkg::ADDR_HMS_DIV && !sfr_wr)
            |=> sfr_rdata_q == hms_div_q)
        else $error("hundred-ms divisor read back wrong");
    ctrl_readback_a: assert property (@(posedge clk) disable iff (!reset_n)
        (sfr_rd && sfr_addr == tpw_pkg::ADDR_GUARD_CTRL && !sfr_wr)
            |=> sfr_rdata_q == {seq_armed_q, guard_timeout_count_q})
        else $error("control register read back wrong");
    unmapped_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        (sfr_rd && sfr_addr < tpw_pkg::ADDR_MS_DIV_LOW) |=> sfr_rdata_q == 8'h00)
        else $error("unmapped address read back nonzero");
endmodule // tpw_guard

// [tb/tpw_testbench.sv]
// Self-checking bench for the tick prescaler and its timeout guard.
// Assumes hdl/ is compiled first; the bench drives the register port itself.
`timescale 1ns/1ps
module testbench;
    logic       clk         = 1'b0;
    logic       reset_n     = 1'b0;
    logic [7:0] sfr_addr    = 8'h00;
    logic       sfr_wr      = 1'b0;
    logic [7:0] sfr_wdata   = 8'h00;
    logic       sfr_rd      = 1'b0;
    logic [7:0] sfr_rdata_q;
    logic       ms_tick_q;
    logic       hms_tick_q;
    logic       guard_running_q;
    logic       guard_expired_q;
    logic       ms_prev     = 1'b0;
    int         expiry_cnt  = 0;
    int         err_count   = 0;
    int         tests_run   = 0;
    int         n;

    always #25 clk = ~clk;
    // Count expiry pulses so idle stretches can be judged by difference
    always @(posedge clk) if (guard_expired_q === 1'b1) expiry_cnt <= expiry_cnt + 1;
    // Last cycle's ms tick, to judge the hundred-ms tick's lag
    always @(posedge clk) ms_prev <= ms_tick_q;

    tpw_guard dut (
        .clk             (clk),
        .reset_n         (reset_n),
        .sfr_addr        (sfr_addr),
        .sfr_wr          (sfr_wr),
        .sfr_wdata       (sfr_wdata),
        .sfr_rd          (sfr_rd),
        .sfr_rdata_q     (sfr_rdata_q),
        .ms_tick_q       (ms_tick_q),
        .hms_tick_q      (hms_tick_q),
        .guard_running_q (guard_running_q),
        .guard_expired_q (guard_expired_q)
    );

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge clk);
        #2;
    endtask

    // Strobe drops one cycle before the next access may raise it again
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        idle(1);
        sfr_wr    = 1'b0;
        idle(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        idle(1);
        sfr_rd   = 1'b0;
        chk({8'h00, sfr_rdata_q}, {8'h00, e});
        idle(1);
    endtask

    // Cycles until the chosen pulse: 0 ms tick, 1 hms tick, 2 expiry
    task automatic gap(input int sel, output int c);
        logic s;
        c = 0;
        do begin
            idle(1);
            c++;
            s = (sel == 0) ? ms_tick_q : (sel == 1) ? hms_tick_q : guard_expired_q;
        end while (s !== 1'b1 && c < 600);
        if (s !== 1'b1) chk({15'h0, s}, 16'h0001);
    endtask

    task automatic test_reset_values;
        rd(8'hFC, 8'h9F);
        rd(8'hFD, 8'h0F);
        rd(8'hFE, 8'h63);
        rd(8'hFF, 8'h00);
        rd(8'hFB, 8'h00);
        $display("test reset_values done");
    endtask

    task automatic test_ticks;
        wr(8'hFD, 8'h01);
        wr(8'hFC, 8'h00);
        gap(0, n);
        gap(0, n);
        chk(16'(n), 16'h0101);
        wr(8'hFD, 8'h00);
        wr(8'hFC, 8'h03);
        wr(8'hFE, 8'h01);
        gap(0, n);
        gap(0, n);
        chk(16'(n), 16'h0004);
        gap(1, n);
        gap(1, n);
        chk(16'(n), 16'h0008);
        chk({15'h0, ms_prev}, 16'h0001);
        $display("test ticks done");
    endtask

    task automatic test_guard;
        int base;
        wr(8'hFF, 8'h01);
        idle(4);
        chk({15'h0, guard_running_q}, 16'h0000);
        wr(8'hFF, 8'h81);
        wr(8'hFF, 8'h01);
        chk({15'h0, guard_running_q}, 16'h0001);
        wr(8'hFF, 8'h21);
        wr(8'hFF, 8'h01);
        gap(2, n);
        // Two to three hms periods of 8 clocks, counted from the edge after the restart
        chk(16'(n >= 16 && n <= 23), 16'h0001);
        idle(1);
        base = expiry_cnt;
        repeat (8) begin
            wr(8'hFF, 8'h21);
            wr(8'hFF, 8'h01);
            idle(2);
        end
        chk(16'(expiry_cnt - base), 16'h0000);
        wr(8'hFF, 8'h41);
        wr(8'hFF, 8'h01);
        chk({15'h0, guard_running_q}, 16'h0000);
        base = expiry_cnt;
        idle(40);
        chk(16'(expiry_cnt - base), 16'h0000);
        rd(8'hFF, 8'h01);
        $display("test guard done");
    endtask

    task automatic test_mid_reset;
        wr(8'hFF, 8'hC1);
        wr(8'hFF, 8'h01);
        // Enable and disable completing in one write: enable wins
        chk({15'h0, guard_running_q}, 16'h0001);
        reset_n = 1'b0;
        idle(2);
        reset_n = 1'b1;
        idle(1);
        chk({15'h0, guard_running_q}, 16'h0000);
        rd(8'hFF, 8'h00);
        rd(8'hFD, 8'h0F);
        rd(8'hFE, 8'h63);
        $display("test mid_reset done");
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #(50 * 8000);
        err_count++;
        complete_run();
    end

    initial begin
        repeat (16) @(posedge clk);
        #2;
        reset_n = 1'b1;
        idle(1);
        test_reset_values();
        test_ticks();
        test_guard();
        test_mid_reset();
        complete_run();
    end
endmodule // testbench
